// ==== bench/dac_model.sv ====
// palette converter model that takes video bytes and stalls at random or on request
`default_nettype none
module dac_model (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic hold,
  input  wire logic video_valid,
  output logic      video_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // stalls one cycle in four so the output register really has to hold its byte
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      video_ready <= 1'b0;
    else
      video_ready <= #1 !hold && ($urandom_range(3) != 0);
  end
endmodule : dac_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench of the attribute palette controller
`include "attr_palette_map.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] io_addr = '0;
  logic        io_rd = 1'b0;
  logic        io_wr = 1'b0;
  logic [7:0]  io_wdata = '0;
  logic [7:0]  seq_index = 8'h83;
  logic [7:0]  io_rdata;
  logic        io_rack;
  logic        pix_valid = 1'b0;
  logic        pix_ready;
  logic        pix_de = 1'b0;
  logic [3:0]  pix_planes = '0;
  logic [7:0]  pix_byte = '0;
  logic [7:0]  pix_char = '0;
  logic [7:0]  pix_attr = '0;
  logic        pix_dot = 1'b0;
  logic        pix_ninth = 1'b0;
  logic        nine_dot = 1'b0;
  logic        line_compare = 1'b0;
  logic        vretrace = 1'b0;
  logic        video_valid;
  logic        video_ready;
  logic [7:0]  video_out;
  logic        byte_pan_zero;
  logic        half_rate_shift;
  logic [3:0]  pan_shift_left;
  logic        pan_shift_right;
  logic        hold = 1'b0;
  logic        saw_full = 1'b0;
  int          mismatches = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          frames = 0;
  logic [7:0]  rd_q[$];
  logic [7:0]  vid_q[$];
  logic [7:0]  pal[16];
  logic [7:0]  mode = '0;
  logic [7:0]  csel = '0;
  logic [7:0]  border = '0;
  logic        ven = 1'b0;
  logic [7:0]  modes[10] = '{8'h01, 8'h03, 8'h81, 8'h41, 8'h00, 8'h04, 8'h84, 8'h09, 8'h0b,
                             8'h08};

  attr_palette_ctrl #(.FIFO_DEPTH(8)) u_dut (
    .core_clk, .rstn, .io_addr, .io_rd, .io_wr, .io_wdata, .seq_index, .io_rdata,
    .io_rack, .pix_valid, .pix_ready, .pix_de, .pix_planes, .pix_byte, .pix_char,
    .pix_attr, .pix_dot, .pix_ninth, .nine_dot, .line_compare, .vretrace, .video_valid,
    .video_ready, .video_out, .pan_shift_left, .pan_shift_right, .byte_pan_zero,
    .half_rate_shift
  );
  dac_model u_dac (.core_clk, .rstn, .hold, .video_valid, .video_ready);

  always #5 core_clk = ~core_clk;

  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one strobe cycle; an edge always passes first so strobes never merge
  task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_wr = wr;
    io_rd = !wr;
    @(posedge core_clk);
    #1;
    io_wr = 1'b0;
    io_rd = 1'b0;
  endtask : io

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    io(1'b0, a, 8'h00);
  endtask : rd

  task automatic setreg(input logic [7:0] i, input logic [7:0] v);
    io(1'b0, `PORT_STATUS_COLOUR, 8'h00);
    io(1'b1, `PORT_INDEX_DATA, i);
    io(1'b1, `PORT_INDEX_DATA, v);
  endtask : setreg

  task automatic getreg(input logic [7:0] i, input logic [7:0] e);
    io(1'b0, `PORT_STATUS_MONO, 8'h00);
    io(1'b1, `PORT_INDEX_DATA, i);
    rd(`PORT_DATA_READ, e);
  endtask : getreg

  function automatic logic [7:0] expv();
    logic       d;
    logic [3:0] a;
    logic [7:0] v;
    if (!ven || !pix_de)
      return border;
    if (mode[6])
      return pix_byte;
    d = pix_ninth ? (mode[2] && pix_char >= `LINE_GFX_FIRST && pix_char <= `LINE_GFX_LAST
                     && pix_dot) : pix_dot;
    if (mode[3] && pix_attr[7] && frames[4])
      d = 1'b0;
    a = d ? pix_attr[3:0] : {pix_attr[7] & !mode[3], pix_attr[6:4]};
    if (mode[0])
    begin
      a = mode[1] ? pix_planes & 4'hd : pix_planes;
      if (mode[3])
        a[3] = (mode[1] || pix_planes[3]) ? frames[4] : 1'b1;
    end
    v = pal[a];
    return {csel[3:2], mode[7] ? csel[1:0] : v[5:4], v[3:0]};
  endfunction : expv

  task automatic px();
    @(posedge core_clk);
    #1;
    pix_valid = 1'b1;
    {pix_planes, pix_byte, pix_attr, pix_dot} = 21'($urandom);
    pix_de = ($urandom_range(7) != 0);
    pix_char = 8'hb0 + 8'($urandom_range(63));
    pix_ninth = nine_dot & 1'($urandom);
    vid_q.push_back(expv());
    while (pix_ready !== 1'b1)
    begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
    pix_valid = 1'b0;
  endtask : px

  task automatic drain();
    repeat (300) if (vid_q.size() != 0) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    #1;
  endtask : drain

  // results are taken in order as they appear and matched against the oldest note
  always @(posedge core_clk)
  begin
    cycles++;
    if (pix_ready === 1'b0)
      saw_full <= 1'b1;
    if (io_rack === 1'b1)
      chk("io_rdata", rd_q.size() != 0 ? rd_q.pop_front() : 8'hxx, io_rdata);
    if (video_valid === 1'b1 && video_ready === 1'b1)
      chk("video_out", vid_q.size() != 0 ? vid_q.pop_front() : 8'hxx, video_out);
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  initial
  begin
    void'($urandom(32'hdcbad124));
    repeat (4) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    io(1'b1, `PORT_INDEX_DATA, 8'h14);
    rd(`PORT_INDEX_DATA, 8'h14);
    csel = {4'h0, 4'($urandom)};
    io(1'b1, `PORT_INDEX_DATA, csel);
    rd(`PORT_DATA_READ, csel);
    io(1'b1, `PORT_INDEX_DATA, 8'h11);
    io(1'b0, `PORT_STATUS_COLOUR, 8'h00);
    border = 8'($urandom);
    io(1'b1, `PORT_INDEX_DATA, 8'h11);
    io(1'b1, `PORT_INDEX_DATA, border);
    getreg(8'h11, border);
    for (int i = 0; i < 16; i++)
    begin
      pal[i] = 8'($urandom);
      setreg(8'(i), pal[i]);
    end
    for (int i = 0; i < 16; i++) getreg(8'(i), pal[i]);
    setreg(8'h15, 8'hff);
    getreg(8'h15, 8'h00);
    io(1'b0, `PORT_STATUS_COLOUR, 8'h00);
    io(1'b1, `PORT_INDEX_DATA, 8'h25);
    rd(`PORT_SEQ_DATA, 8'ha5);
    seq_index = 8'h84;
    io(1'b0, `PORT_SEQ_DATA, 8'h00);
    seq_index = `SEQ_EXT_ATTR_INDEX;
    io(1'b1, `PORT_SEQ_DATA, 8'h12);
    rd(`PORT_SEQ_DATA, 8'h12);
    io(1'b1, `PORT_INDEX_DATA, 8'h13);
    rd(`PORT_INDEX_DATA, 8'h13);
    foreach (modes[k])
    begin
      mode = modes[k];
      nine_dot = k[0];
      setreg({3'h0, `IDX_MODE}, mode);
      // sixteen frames flip the blink phase, so each blink mode sees the other phase
      if (mode[3])
        repeat (16)
        begin
          vretrace = 1'b1;
          @(posedge core_clk);
          #1;
          vretrace = 1'b0;
          frames++;
          @(posedge core_clk);
          #1;
        end
      ven = 1'b0;
      repeat (2) px();
      drain();
      chk("half_rate_shift", {7'h0, mode[6]}, {7'h0, half_rate_shift});
      io(1'b0, `PORT_STATUS_COLOUR, 8'h00);
      io(1'b1, `PORT_INDEX_DATA, 8'h20);
      ven = 1'b1;
      if (k == 0)
        fork
        begin
          hold = 1'b1;
          repeat (60) @(posedge core_clk);
          #1;
          hold = 1'b0;
        end
        join_none
      repeat (24) px();
      drain();
    end
    chk("fifo_refused", 8'h01, {7'h0, saw_full});
    setreg({3'h0, `IDX_FINE_PAN}, 8'h03);
    setreg({3'h0, `IDX_MODE}, 8'h20);
    nine_dot = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("pan_shift_left", 8'h04, {4'h0, pan_shift_left});
    line_compare = 1'b1;
    @(posedge core_clk);
    #1;
    line_compare = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk("byte_pan_zero", 8'h01, {7'h0, byte_pan_zero});
    chk("pan_shift_left", 8'h01, {4'h0, pan_shift_left});
    chk("pan_shift_right", 8'h00, {7'h0, pan_shift_right});
    vretrace = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("byte_pan_zero", 8'h00, {7'h0, byte_pan_zero});
    chk("pan_shift_left", 8'h04, {4'h0, pan_shift_left});
    chk("pending", 8'h00, 8'(rd_q.size() + vid_q.size()));
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

// ==== rtl/attr_palette_ctrl.sv ====
// attribute palette controller: host port, colour mapping, blink, panning suppression
// Function
// R1 - a 5-bit index field selects the data register for later data accesses
// R2 - toggle 0 sends next shared-port access to index, 1 to data registers
// R3 - reading display status port clears toggle; host reads it before indexing
// R4 - each shared-port write inverts the toggle; reads leave it alone
// R5 - shared port reads back the index, read port returns the selected data
// R6 - sequencer extension index reads and writes toggle plus index bits
// R7 - extension reads never change toggle or index; extension writes load both
// R8 - index bit 5 low shows border colour, high shows normal video
// R9 - index bit 5 picks palette address source; host writes entries while low
// R10 - sixteen 8-bit colour entries at index 00h to 0Fh
// R11 - 4-bit colour addresses the entries except in 256-colour mode, bypassed
// R12 - video bits 6-7 come from colour-select bits 2-3
// R13 - mode bit 7 picks video bits 4-5 source; ignored in 256-colour mode
// R14 - mode bit 6 halves shift rate and passes all 8 bits straight out
// R15 - pan-compat bit forces panning outputs zero from line compare to retrace
// R16 - forced zero pan in 9-dot mode still shifts one pixel left
// R17 - blink phase holds 16 frames each, toggling every 16 retraces
// R18 - blinking toggles the top palette address bit, entries 0-7 versus 8-F
// R19 - 9-dot text with line graphics copies dot 8 to 9 for C0h-DFh
// R20 - monochrome four-colour pixels feed planes 0 and 2, plane 1 zero, plane 3 unchanged
// R21 - graphics address bit 3 follows plane 3, forced or blinked per table
// R22 - text blink alternates foreground and non-intensified background
// R23 - reset clears the toggle so the first shared-port write is an index
`include "attr_palette_map.svh"
`default_nettype none
module attr_palette_ctrl #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic [7:0]  seq_index,
  output logic      [7:0]  io_rdata,
  output logic             io_rack,
  input  wire logic        pix_valid,
  output logic             pix_ready,
  input  wire logic        pix_de,
  input  wire logic [3:0]  pix_planes,
  input  wire logic [7:0]  pix_byte,
  input  wire logic [7:0]  pix_char,
  input  wire logic [7:0]  pix_attr,
  input  wire logic        pix_dot,
  input  wire logic        pix_ninth,
  input  wire logic        nine_dot,
  input  wire logic        line_compare,
  input  wire logic        vretrace,
  output logic             video_valid,
  input  wire logic        video_ready,
  output logic      [7:0]  video_out,
  output logic      [3:0]  pan_shift_left,
  output logic             pan_shift_right,
  output logic             byte_pan_zero,
  output logic             half_rate_shift
);
  localparam int FW = 31;
  logic                  toggle_r;
  logic [5:0]            index_r;
  attr_palette_pkg::byte_t mode_r;
  attr_palette_pkg::byte_t border_r;
  attr_palette_pkg::byte_t plane_en_r;
  attr_palette_pkg::byte_t fine_pan_r;
  attr_palette_pkg::byte_t csel_r;
  logic                  wr_shared;
  logic                  rd_shared;
  logic                  rd_data;
  logic                  rd_status;
  logic                  ext_hit;
  logic                  data_wr;
  logic                  map_wr;
  logic [3:0]            map_wr_addr;
  logic                  video_en;
  logic [2:0]            rd_sel_r;
  logic                  rd_pend_r;
  attr_palette_pkg::byte_t rd_hold_r;
  logic [FW-1:0]         f_in;
  logic [FW-1:0]         f_out;
  logic                  f_valid;
  logic                  f_pop;
  logic                  f_de;
  logic [3:0]            f_planes;
  logic [7:0]            f_byte;
  logic [7:0]            f_char;
  logic [7:0]            f_attr;
  logic                  f_dot;
  logic                  f_ninth;
  logic                  s1_valid_r;
  attr_palette_pkg::pix_kind_t s1_kind_r;
  logic [7:0]            s1_byte_r;
  logic [3:0]            s1_addr_r;
  logic                  s1_adv;
  attr_palette_pkg::byte_t map_vid;
  attr_palette_pkg::byte_t map_cpu;
  logic [3:0]            pix_addr;
  attr_palette_pkg::pix_kind_t pix_kind;
  logic [`BLINK_CNT_W-1:0] frame_cnt_r;
  logic                  vret_d_r;
  logic                  vret_rise;
  logic                  blink_phase;
  logic                  split_r;
  logic [3:0]            pan_l_nxt;
  logic                  pan_r_nxt;
  logic [3:0]            pan_cnt;

  assign wr_shared = io_wr && (io_addr == `PORT_INDEX_DATA);
  assign rd_shared = io_rd && (io_addr == `PORT_INDEX_DATA);
  assign rd_data   = io_rd && (io_addr == `PORT_DATA_READ);
  assign rd_status = io_rd && ((io_addr == `PORT_STATUS_MONO) ||
                               (io_addr == `PORT_STATUS_COLOUR));
  assign ext_hit   = (io_addr == `PORT_SEQ_DATA) && (seq_index == `SEQ_EXT_ATTR_INDEX);
  assign data_wr   = wr_shared && toggle_r; // R2
  assign video_en  = index_r[`INDEX_VIDEO_EN_BIT];
  // with video enabled the entry address comes from the pixel stream, as on the original
  assign map_wr      = data_wr && (index_r[4:0] <= `IDX_MAP_LAST); // R10
  assign map_wr_addr = video_en ? s1_addr_r : index_r[3:0]; // R9

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      toggle_r <= 1'b0; // R23
    else if (io_wr && ext_hit)
      toggle_r <= io_wdata[`EXT_TOGGLE_BIT]; // R6
    else if (wr_shared)
      toggle_r <= !toggle_r; // R4
    else if (rd_status)
      toggle_r <= 1'b0; // R3
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      index_r <= 6'h00;
    else if (io_wr && ext_hit)
      index_r <= io_wdata[5:0]; // R7
    else if (wr_shared && !toggle_r)
      index_r <= io_wdata[5:0]; // R1
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_r     <= `REG_RESET;
      border_r   <= `REG_RESET;
      plane_en_r <= `PLANE_EN_RESET;
      fine_pan_r <= `REG_RESET;
      csel_r     <= `REG_RESET;
    end
    else if (data_wr)
    begin
      if (index_r[4:0] == `IDX_MODE)
        mode_r <= io_wdata;
      else if (index_r[4:0] == `IDX_BORDER)
        border_r <= io_wdata;
      else if (index_r[4:0] == `IDX_PLANE_EN)
        plane_en_r <= {4'h0, io_wdata[3:0]};
      else if (index_r[4:0] == `IDX_FINE_PAN)
        fine_pan_r <= {4'h0, io_wdata[3:0]};
      else if (index_r[4:0] == `IDX_COLOUR_SEL)
        csel_r <= {4'h0, io_wdata[3:0]};
    end
  end

  // reads answer two edges later so palette entries come out of the memory register
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_pend_r <= 1'b0;
      rd_sel_r  <= 3'h0;
      rd_hold_r <= `REG_RESET;
      io_rack   <= 1'b0;
      io_rdata  <= `REG_RESET;
    end
    else
    begin
      rd_pend_r <= rd_shared || rd_data || (io_rd && ext_hit);
      io_rack   <= rd_pend_r;
      if (rd_shared)
      begin
        rd_sel_r  <= 3'h0;
        rd_hold_r <= {2'h0, index_r}; // R5
      end
      else if (io_rd && ext_hit)
      begin
        rd_sel_r  <= 3'h0;
        rd_hold_r <= {toggle_r, 1'b0, index_r}; // R6
      end
      else if (rd_data)
      begin
        if (index_r[4:0] <= `IDX_MAP_LAST)
          rd_sel_r <= 3'h1; // R5
        else
          rd_sel_r <= 3'h0;
        if (index_r[4:0] == `IDX_MODE)
          rd_hold_r <= mode_r;
        else if (index_r[4:0] == `IDX_BORDER)
          rd_hold_r <= border_r;
        else if (index_r[4:0] == `IDX_PLANE_EN)
          rd_hold_r <= plane_en_r;
        else if (index_r[4:0] == `IDX_FINE_PAN)
          rd_hold_r <= fine_pan_r;
        else if (index_r[4:0] == `IDX_COLOUR_SEL)
          rd_hold_r <= csel_r;
        else
          rd_hold_r <= `REG_RESET;
      end
      if (rd_pend_r)
        io_rdata <= (rd_sel_r == 3'h1) ? map_cpu : rd_hold_r;
    end
  end

  // frame counter: one blink phase per 16 retraces
  assign vret_rise   = vretrace && !vret_d_r;
  assign blink_phase = frame_cnt_r[`BLINK_PHASE_BIT]; // R17
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      vret_d_r    <= 1'b0;
      frame_cnt_r <= '0;
    end
    else
    begin
      vret_d_r <= vretrace;
      if (vret_rise)
        frame_cnt_r <= frame_cnt_r + `BLINK_CNT_W'(1); // R17
    end
  end

  // lower split-screen half: held from line compare to the next retrace
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      split_r <= 1'b0;
    else if (line_compare)
      split_r <= 1'b1; // R15
    else if (vret_rise)
      split_r <= 1'b0; // R15
  end

  assign pan_cnt = (mode_r[`MODE_PAN_COMPAT_BIT] && split_r) ? 4'h0 : fine_pan_r[3:0]; // R15
  always_comb
  begin
    pan_l_nxt = 4'h0;
    pan_r_nxt = 1'b0;
    if (mode_r[`MODE_WIDE_PIX_BIT])
    begin
      if (pan_cnt[3])
        pan_r_nxt = 1'b1;
      else
        pan_l_nxt = {2'h0, pan_cnt[2:1]};
    end
    else if (nine_dot)
    begin
      if (!pan_cnt[3])
        pan_l_nxt = pan_cnt + 4'h1; // R16
    end
    else if (pan_cnt[3])
      pan_r_nxt = 1'b1;
    else
      pan_l_nxt = pan_cnt;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pan_shift_left  <= 4'h0;
      pan_shift_right <= 1'b0;
      byte_pan_zero   <= 1'b0;
      half_rate_shift <= 1'b0;
    end
    else
    begin
      pan_shift_left  <= pan_l_nxt;
      pan_shift_right <= pan_r_nxt;
      byte_pan_zero   <= mode_r[`MODE_PAN_COMPAT_BIT] && (split_r || line_compare); // R15
      half_rate_shift <= mode_r[`MODE_WIDE_PIX_BIT]; // R14
    end
  end

  assign f_in = {pix_de, pix_planes, pix_byte, pix_char, pix_attr, pix_dot, pix_ninth};
  assign {f_de, f_planes, f_byte, f_char, f_attr, f_dot, f_ninth} = f_out;

  pix_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .in_data   (f_in),
    .out_valid (f_valid),
    .out_ready (!s1_valid_r || s1_adv),
    .out_data  (f_out)
  );

  assign f_pop  = f_valid && (!s1_valid_r || s1_adv);
  assign s1_adv = s1_valid_r && (!video_valid || video_ready);

  // palette address of the popped pixel
  always_comb
  begin
    logic [3:0] pl;
    logic       dot;
    logic [3:0] bg;
    pl       = f_planes & plane_en_r[3:0];
    dot      = f_dot;
    bg       = 4'h0;
    pix_addr = 4'h0;
    pix_kind = attr_palette_pkg::PIX_MAPPED;
    if (!video_en || !f_de)
      pix_kind = attr_palette_pkg::PIX_BORDER; // R8
    else if (mode_r[`MODE_WIDE_PIX_BIT])
      pix_kind = attr_palette_pkg::PIX_DIRECT; // R11
    if (mode_r[`MODE_GFX_BIT])
    begin
      if (mode_r[`MODE_MONO_BIT])
        pl = {pl[3], pl[2], 1'b0, pl[0]}; // R20
      pix_addr[2:0] = pl[2:0];
      if (!mode_r[`MODE_BLINK_BIT])
        pix_addr[3] = pl[3]; // R21
      else if (!mode_r[`MODE_MONO_BIT])
        pix_addr[3] = pl[3] ? blink_phase : 1'b1; // R21
      else
        pix_addr[3] = blink_phase; // R18
    end
    else
    begin
      if (f_ninth)
        dot = mode_r[`MODE_LINE_GFX_BIT] && nine_dot && (f_char >= `LINE_GFX_FIRST) &&
              (f_char <= `LINE_GFX_LAST) && f_dot; // R19
      bg = mode_r[`MODE_BLINK_BIT] ? {1'b0, f_attr[6:4]} : f_attr[7:4]; // R22
      if (mode_r[`MODE_BLINK_BIT] && f_attr[7] && blink_phase)
        dot = 1'b0; // R22
      pix_addr = dot ? f_attr[3:0] : bg;
    end
  end

  colour_map_mem #(
    .WIDTH   (8),
    .ENTRIES (16)
  ) u_map (
    .core_clk  (core_clk),
    .wr_en     (map_wr),
    .wr_addr   (map_wr_addr),
    .wr_data   (io_wdata),
    .vid_rd_en (f_pop),
    .vid_addr  (pix_addr),
    .vid_data  (map_vid),
    .cpu_rd_en (rd_data),
    .cpu_addr  (index_r[3:0]),
    .cpu_data  (map_cpu)
  );

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_valid_r <= 1'b0;
      s1_kind_r  <= attr_palette_pkg::PIX_BORDER;
      s1_byte_r  <= 8'h00;
      s1_addr_r  <= 4'h0;
    end
    else if (f_pop)
    begin
      s1_valid_r <= 1'b1;
      s1_kind_r  <= pix_kind;
      s1_byte_r  <= f_byte;
      s1_addr_r  <= pix_addr; // R11
    end
    else if (s1_adv)
      s1_valid_r <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      video_valid <= 1'b0;
      video_out   <= 8'h00;
    end
    else if (s1_adv)
    begin
      video_valid <= 1'b1;
      case (s1_kind_r)
        attr_palette_pkg::PIX_BORDER: video_out <= border_r; // R8
        attr_palette_pkg::PIX_DIRECT: video_out <= s1_byte_r; // R14
        default:
          video_out <= {csel_r[3:2], // R12
                        mode_r[`MODE_ALT_SRC_BIT] ? csel_r[1:0] : map_vid[5:4], // R13
                        map_vid[3:0]};
      endcase
    end
    else if (video_ready)
      video_valid <= 1'b0;
  end

  AST_TOGGLE_FLIP: assert property (@(posedge core_clk) disable iff (!rstn) // R4
    wr_shared |=> toggle_r == !$past(toggle_r))
    else $error("shared port write did not invert toggle");
  AST_TOGGLE_READ: assert property (@(posedge core_clk) disable iff (!rstn) // R4
    (rd_shared || rd_data) && !io_wr |=> $stable(toggle_r))
    else $error("shared port read moved toggle");
  AST_STATUS_CLEAR: assert property (@(posedge core_clk) disable iff (!rstn) // R3
    rd_status && !io_wr |=> !toggle_r)
    else $error("status read did not clear toggle");
  AST_EXT_READ: assert property (@(posedge core_clk) disable iff (!rstn) // R7
    io_rd && ext_hit && !io_wr |=> $stable(toggle_r) && $stable(index_r))
    else $error("extension read changed index or toggle");
  AST_INDEX_LOAD: assert property (@(posedge core_clk) disable iff (!rstn) // R1
    wr_shared && !toggle_r |=> index_r == $past(io_wdata[5:0]))
    else $error("index write lost");
  AST_INDEX_READ: assert property (@(posedge core_clk) disable iff (!rstn) // R5
    rd_shared |-> ##2 io_rack && io_rdata == {2'h0, $past(index_r, 2)})
    else $error("index readback wrong");
  AST_SPLIT_PAN: assert property (@(posedge core_clk) disable iff (!rstn) // R15
    line_compare && mode_r[`MODE_PAN_COMPAT_BIT] && !vret_rise ##1
    mode_r[`MODE_PAN_COMPAT_BIT] && !vret_rise |-> byte_pan_zero)
    else $error("byte panning not forced after line compare");
  AST_BLINK_STEP: assert property (@(posedge core_clk) disable iff (!rstn) // R17
    $changed(blink_phase) |-> $past(vret_rise) && $past(frame_cnt_r[3:0]) == 4'hf)
    else $error("blink phase moved off the 16-frame boundary");
  AST_BYPASS: assert property (@(posedge core_clk) disable iff (!rstn) // R14
    s1_adv && s1_kind_r == attr_palette_pkg::PIX_DIRECT |=> video_out == $past(s1_byte_r))
    else $error("256-colour byte not passed straight");
  COV_DATA_WR: cover property (@(posedge core_clk) disable iff (!rstn) map_wr);
  COV_SPLIT: cover property (@(posedge core_clk) disable iff (!rstn) split_r && vret_rise);
  COV_BLINK: cover property (@(posedge core_clk) disable iff (!rstn) $rose(blink_phase));
  COV_STALL: cover property (@(posedge core_clk) disable iff (!rstn) !pix_ready);
endmodule : attr_palette_ctrl
`default_nettype wire

// ==== rtl/attr_palette_map.svh ====
// offsets, field positions, reset values and counts of the attribute palette controller
`ifndef ATTR_PALETTE_MAP_SVH
`define ATTR_PALETTE_MAP_SVH
`define PORT_INDEX_DATA    16'h03c0
`define PORT_DATA_READ     16'h03c1
`define PORT_STATUS_MONO   16'h03ba
`define PORT_STATUS_COLOUR 16'h03da
`define PORT_SEQ_DATA      16'h03c5
`define SEQ_EXT_ATTR_INDEX 8'h83
`define IDX_MODE           5'h10
`define IDX_BORDER         5'h11
`define IDX_PLANE_EN       5'h12
`define IDX_FINE_PAN       5'h13
`define IDX_COLOUR_SEL     5'h14
`define IDX_MAP_LAST       5'h0f
`define INDEX_VIDEO_EN_BIT 5
`define EXT_TOGGLE_BIT     7
`define MODE_GFX_BIT       0
`define MODE_MONO_BIT      1
`define MODE_LINE_GFX_BIT  2
`define MODE_BLINK_BIT     3
`define MODE_PAN_COMPAT_BIT 5
`define MODE_WIDE_PIX_BIT  6
`define MODE_ALT_SRC_BIT   7
`define REG_RESET          8'h00
`define PLANE_EN_RESET     8'h0f
`define LINE_GFX_FIRST     8'hc0
`define LINE_GFX_LAST      8'hdf
`define BLINK_CNT_W        5
`define BLINK_PHASE_BIT    4
`endif

// ==== rtl/attr_palette_pkg.sv ====
// types shared by the attribute palette controller
`default_nettype none
package attr_palette_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {PIX_MAPPED, PIX_DIRECT, PIX_BORDER} pix_kind_t;
endpackage : attr_palette_pkg
`default_nettype wire

// ==== rtl/colour_map_mem.sv ====
// sixteen colour entries, one write port and two registered read ports
`default_nettype none
module colour_map_mem #(
  parameter int WIDTH   = 8,
  parameter int ENTRIES = 16
) (
  input  wire logic                       core_clk,
  input  wire logic                       wr_en,
  input  wire logic [$clog2(ENTRIES)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]           wr_data,
  input  wire logic                       vid_rd_en,
  input  wire logic [$clog2(ENTRIES)-1:0] vid_addr,
  output logic      [WIDTH-1:0]           vid_data,
  input  wire logic                       cpu_rd_en,
  input  wire logic [$clog2(ENTRIES)-1:0] cpu_addr,
  output logic      [WIDTH-1:0]           cpu_data
);
  logic [WIDTH-1:0] mem_r [ENTRIES];
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
      mem_r[wr_addr] <= wr_data;
    if (vid_rd_en)
      vid_data <= mem_r[vid_addr];
    if (cpu_rd_en)
      cpu_data <= mem_r[cpu_addr];
  end
endmodule : colour_map_mem
`default_nettype wire

// ==== rtl/pix_fifo.sv ====
// pixel fifo with valid/ready on both sides
`default_nettype none
module pix_fifo #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rp_r];
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + AW'(1);
      if (pop)
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pix_fifo
`default_nettype wire
